/* File: design/irq_pkg.sv */
// package: register map, field layouts and types of the interrupt request front end
package irqf_pkg;
   localparam logic [7:0] IRQF_CTRL_OFF = 8'h00;
   localparam logic [7:0] IRQF_MODE_OFF = 8'h04;
   localparam logic [7:0] IRQF_ROUTE_OFF = 8'h08;
   localparam logic [7:0] IRQF_STAT_OFF = 8'h0c;
   localparam logic [7:0] IRQF_MASK_OFF = 8'h10;
   localparam logic [7:0] IRQF_PEND_OFF = 8'h14;
   localparam logic [7:0] IRQF_GPIO_OFF = 8'h18;
   localparam logic [7:0] IRQF_VEC_OFF = 8'h1c;
   // control bits
   localparam int IRQF_CTL_APIC = 0;
   localparam int IRQF_CTL_MOUSE = 1;
   localparam int IRQF_CTL_RTC_GPI = 2;
   localparam int IRQF_CTL_SER_GPI = 3;
   localparam int IRQF_CTL_GPO = 4;
   localparam int IRQF_CTL_SYSCTL = 5;
   localparam int IRQF_CTL_SMB = 6;
   localparam int IRQF_CTL_ACK = 7;
   localparam logic [31:0] IRQF_CTRL_RST = 32'h0000_0010;
   localparam logic [15:0] IRQF_MODE_RST = 16'h0000;
   // request lines that may be programmed level sensitive
   localparam logic [15:0] IRQF_LEVEL_OK = 16'hcef8;
   // legal steering targets for the shared lines
   localparam logic [15:0] IRQF_ROUTE_OK = 16'hdef8;
   localparam logic [3:0] IRQF_DEFAULT_VEC = 4'h7;
   localparam logic [3:0] IRQF_RTC_LINE = 4'h8;
   localparam logic [3:0] IRQF_MOUSE_LINE = 4'hc;
   localparam logic [15:0] IRQF_ROUTE_RST = 16'h0000;
   localparam logic [3:0] IRQF_PORT60 = 4'h0;
   localparam int IRQF_SER_FRAMES = 16;
   localparam logic [1:0] IRQF_RESP_OKAY = 2'b00;
   localparam logic [1:0] IRQF_RESP_SLVERR = 2'b10;
   // status bits: edge seen, withdrawn, serial frame, ack done
   localparam int IRQF_EV_NUM = 4;
   localparam logic [3:0] IRQF_EV_RST = 4'h0;

   typedef struct packed {
      logic [3:0] shared_n;
      logic [15:0] req;
      logic clock_alarm_n;
      logic serial;
      logic iord_n;
   } irqf_pins_t;

   typedef struct packed {
      logic ena;
      logic [3:0] line;
   } irqf_route_t;
endpackage : irqf_pkg

/* File: design/irq_front_end.sv */
// interrupt request input front end with axi4-lite register slave
// How it works
// R1 - lines 3-7, 9-11, 14-15 each edge or high level; edge after reset
// R2 - requesting devices hold their request until the cpu acknowledges it
// R3 - request withdrawn before acknowledge answers with default vector 7
// R4 - clock alarm line is active-low edge only, never programmable
// R5 - clock alarm source holds its request until acknowledge or gets vector 7
// R6 - alarm pin can be a general input unless apic enabled, then an output
// R7 - apic on: control and bus interrupts drive routed output; else gpo, high at reset
// R8 - mouse mode latches rising edge on line 12 as request 12
// R9 - mouse latch clears on reset or port 60 read at read strobe fall
// R10 - four active-low level shared lines each steered to a legal isa line
// R11 - usb controller signals by pulling the fourth shared line low
// R12 - serial request pin decoded, or general input when serial unused
// R13 - cpu interrupt output high whenever a request is pending
// R14 - every asynchronous input passes two flip-flops before use; usb_irq, io_addr_lo and the control and bus interrupts skip them
`timescale 1ns/1ns
`default_nettype none
module irqf_front_end
   import irqf_pkg::*;
#(
   parameter int NUM_SHARED = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire irqf_pkg::irqf_pins_t pins,
   input wire logic usb_irq,
   input wire logic system_control_interrupt,
   input wire logic smbus_irq,
   input wire logic [3:0] io_addr_lo,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic shared_pci_request_d_n,
   output logic shared_pci_request_d_oe,
   output logic clock_alarm_request_n_out,
   output logic clock_alarm_request_n_oe,
   output logic apic_routed_request_out_n,
   output logic cpu_interrupt_out,
   output logic irq_out
);
   import irqf_pkg::*;

   typedef enum logic [1:0] {SER_IDLE, SER_START, SER_FRAME} irqf_ser_t;

   function automatic logic [15:0] irqf_onehot(input irqf_route_t r);
      irqf_onehot = (r.ena && IRQF_ROUTE_OK[r.line]) ? (16'h0001 << r.line) : 16'h0000;
   endfunction : irqf_onehot

   // two flip-flop input synchronisers
   irqf_pins_t meta_reg, sync_reg, prev_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= '{shared_n: 4'hf, req: 16'h0000, clock_alarm_n: 1'b1, serial: 1'b1,
            iord_n: 1'b1};
         sync_reg <= '{shared_n: 4'hf, req: 16'h0000, clock_alarm_n: 1'b1, serial: 1'b1,
            iord_n: 1'b1};
         prev_reg <= '{shared_n: 4'hf, req: 16'h0000, clock_alarm_n: 1'b1, serial: 1'b1,
            iord_n: 1'b1};
      end else if (clk_en) begin
         meta_reg <= pins; // see R14
         sync_reg <= meta_reg; // see R14
         prev_reg <= sync_reg;
      end
   end

   // registers
   logic [31:0] ctrl_reg;
   logic [15:0] mode_reg, route_reg, pend_reg, ser_reg;
   logic [3:0] stat_reg, mask_reg, vec_reg;
   logic mouse_reg;

   wire apic_on = ctrl_reg[IRQF_CTL_APIC];
   wire mouse_on = ctrl_reg[IRQF_CTL_MOUSE];
   wire [15:0] level_mode = mode_reg & IRQF_LEVEL_OK; // see R1
   wire [15:0] rise = sync_reg.req & ~prev_reg.req;
   wire alarm_fall = prev_reg.clock_alarm_n & ~sync_reg.clock_alarm_n; // see R4
   wire iord_fall = prev_reg.iord_n & ~sync_reg.iord_n;
   wire port60_rd = iord_fall && io_addr_lo == IRQF_PORT60; // see R9

   // shared lines: active low level, steered per route nibble
   logic [15:0] shared_vec;
   always_comb begin
      shared_vec = 16'h0000;
      for (int i = 0; i < NUM_SHARED; i++) begin
         if (!sync_reg.shared_n[i]) begin
            shared_vec = shared_vec |
               irqf_onehot(irqf_route_t'({1'b1, route_reg[4*i +: 4]})); // see R10
         end
      end
   end

   // edge requests latched, level ones follow the line
   wire [15:0] edge_set = rise & ~level_mode & IRQF_LEVEL_OK;
   wire [15:0] live_level = sync_reg.req & level_mode;
   wire [15:0] rtc_vec = alarm_fall ? (16'h0001 << IRQF_RTC_LINE) : 16'h0000;
   wire [15:0] mouse_vec = mouse_reg ? (16'h0001 << IRQF_MOUSE_LINE) : 16'h0000;
   wire [15:0] ack_hold = (sync_reg.req & IRQF_LEVEL_OK)
      | (sync_reg.clock_alarm_n ? 16'h0000 : (16'h0001 << IRQF_RTC_LINE))
      | mouse_vec | shared_vec | ser_reg;
   wire [15:0] pend_now = pend_reg | live_level | shared_vec | mouse_vec | ser_reg;

   // axi write path
   logic [31:0] awaddr_reg, wdata_reg;
   logic aw_have_reg, w_have_reg;
   wire do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
   wire [7:0] wr_off = awaddr_reg[7:0];
   wire wr_ctrl = do_write && wr_off == IRQF_CTRL_OFF;
   wire wr_mode = do_write && wr_off == IRQF_MODE_OFF;
   wire wr_route = do_write && wr_off == IRQF_ROUTE_OFF;
   wire wr_stat = do_write && wr_off == IRQF_STAT_OFF;
   wire wr_mask = do_write && wr_off == IRQF_MASK_OFF;
   wire wr_known = wr_ctrl | wr_mode | wr_route | wr_stat | wr_mask;
   wire ack_pulse = wr_ctrl && wdata_reg[IRQF_CTL_ACK];

   // acknowledge picks the lowest numbered pending line, vector 7 if it is no longer held
   logic [3:0] ack_line;
   logic ack_found;
   always_comb begin
      ack_line = IRQF_DEFAULT_VEC;
      ack_found = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         if (pend_now[i]) begin
            ack_line = 4'(i);
            ack_found = 1'b1;
         end
      end
   end
   wire ack_held = ack_found && ack_hold[ack_line];
   wire [3:0] ack_vec = ack_held ? ack_line : IRQF_DEFAULT_VEC; // see R3 R5
   wire [15:0] ack_clear = (ack_pulse && ack_found) ? (16'h0001 << ack_line) : 16'h0000;

   // sticky events: edge, withdrawn, serial frame, acknowledge
   wire ser_done;
   wire [3:0] ev = {ack_pulse, ser_done, ack_pulse & ack_found & ~ack_held,
      |(edge_set | rtc_vec)};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= IRQF_CTRL_RST;
         mode_reg <= IRQF_MODE_RST; // see R1
         route_reg <= IRQF_ROUTE_RST;
         mask_reg <= IRQF_EV_RST;
         stat_reg <= IRQF_EV_RST;
         pend_reg <= 16'h0000;
         vec_reg <= IRQF_DEFAULT_VEC;
      end else if (clk_en) begin
         if (wr_ctrl) ctrl_reg <= wdata_reg & ~(32'h1 << IRQF_CTL_ACK);
         if (wr_mode) mode_reg <= wdata_reg[15:0] & IRQF_LEVEL_OK; // see R1
         if (wr_route) route_reg <= wdata_reg[15:0]; // see R10
         if (wr_mask) mask_reg <= wdata_reg[IRQF_EV_NUM-1:0];
         stat_reg <= (stat_reg & ~(wr_stat ? wdata_reg[3:0] : 4'h0)) | ev;
         pend_reg <= ((pend_reg | edge_set | rtc_vec) & ~ack_clear) & ~level_mode;
         if (ack_pulse) vec_reg <= ack_vec; // see R3 R5
      end
   end

   // mouse latch
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mouse_reg <= 1'b0; // see R9
      end else if (clk_en) begin
         if (mouse_on && rise[IRQF_MOUSE_LINE]) mouse_reg <= 1'b1; // see R8
         else if (port60_rd || !mouse_on) mouse_reg <= 1'b0; // see R9
      end
   end

   // serial request decoder: start low pulse, then one slot per line
   irqf_ser_t ser_state;
   logic [4:0] slot_reg;
   logic [15:0] ser_next;
   wire ser_use = !ctrl_reg[IRQF_CTL_SER_GPI]; // see R12
   assign ser_done = ser_state == SER_FRAME && slot_reg == 5'(IRQF_SER_FRAMES - 1);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ser_state <= SER_IDLE;
         slot_reg <= 5'h00;
         ser_reg <= 16'h0000;
         ser_next <= 16'h0000;
      end else if (clk_en) begin
         case (ser_state)
            SER_IDLE: begin
               if (ser_use && !sync_reg.serial) ser_state <= SER_START;
            end
            SER_START: begin
               if (sync_reg.serial) begin
                  ser_state <= SER_FRAME;
                  slot_reg <= 5'h00;
               end
            end
            SER_FRAME: begin
               ser_next[slot_reg[3:0]] <= !sync_reg.serial; // see R12
               slot_reg <= slot_reg + 5'h01;
               if (ser_done) begin
                  ser_state <= SER_IDLE;
                  ser_reg <= (ser_next & ~(16'h0001 << slot_reg[3:0]))
                     | ({15'h0000, !sync_reg.serial} << slot_reg[3:0]); // see R12
               end
            end
            default: ser_state <= SER_IDLE;
         endcase
         if (!ser_use) ser_reg <= 16'h0000;
      end
   end

   // axi handshake and read path
   logic [31:0] rdata_mux;
   wire [7:0] rd_off = s_axi_araddr[7:0];
   always_comb begin
      case (rd_off)
         IRQF_CTRL_OFF: rdata_mux = ctrl_reg;
         IRQF_MODE_OFF: rdata_mux = {16'h0000, mode_reg};
         IRQF_ROUTE_OFF: rdata_mux = {16'h0000, route_reg};
         IRQF_STAT_OFF: rdata_mux = {28'h0000000, stat_reg};
         IRQF_MASK_OFF: rdata_mux = {28'h0000000, mask_reg};
         IRQF_PEND_OFF: rdata_mux = {16'h0000, pend_now};
         IRQF_GPIO_OFF: rdata_mux = {30'h00000000, sync_reg.serial,
            sync_reg.clock_alarm_n}; // see R6 R12
         IRQF_VEC_OFF: rdata_mux = {28'h0000000, vec_reg};
         default: rdata_mux = 32'h0000_0000;
      endcase
   end
   wire rd_known = rd_off inside {IRQF_CTRL_OFF, IRQF_MODE_OFF, IRQF_ROUTE_OFF,
      IRQF_STAT_OFF, IRQF_MASK_OFF, IRQF_PEND_OFF, IRQF_GPIO_OFF, IRQF_VEC_OFF};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         awaddr_reg <= 32'h0000_0000;
         wdata_reg <= 32'h0000_0000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= IRQF_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= IRQF_RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
         end
         if (do_write) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? IRQF_RESP_OKAY : IRQF_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_mux;
            s_axi_rresp <= rd_known ? IRQF_RESP_OKAY : IRQF_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
   assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   // registered pin outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpu_interrupt_out <= 1'b0;
         irq_out <= 1'b0;
         apic_routed_request_out_n <= 1'b1; // see R7
         shared_pci_request_d_n <= 1'b1;
         shared_pci_request_d_oe <= 1'b0;
         clock_alarm_request_n_out <= 1'b1;
         clock_alarm_request_n_oe <= 1'b0;
      end else if (clk_en) begin
         cpu_interrupt_out <= |pend_now; // see R13
         irq_out <= |(stat_reg & mask_reg);
         apic_routed_request_out_n <= apic_on ?
            !(system_control_interrupt | smbus_irq) : ctrl_reg[IRQF_CTL_GPO]; // see R7
         shared_pci_request_d_n <= 1'b0;
         shared_pci_request_d_oe <= usb_irq; // see R11
         clock_alarm_request_n_out <= !(system_control_interrupt | smbus_irq);
         clock_alarm_request_n_oe <= apic_on; // see R6
      end
   end

   // checks
   property cpu_follows_p;
      @(posedge aclk) disable iff (!aresetn) clk_en |=> cpu_interrupt_out == $past(|pend_now);
   endproperty
   cpu_out_tracks_a: assert property (cpu_follows_p) // see R13
      else $error("cpu interrupt does not follow pending requests");
   apic_out_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R7
      clk_en && apic_on && (system_control_interrupt | smbus_irq) |=> !apic_routed_request_out_n)
      else $error("routed request not driven low");
   alarm_oe_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R6
      clk_en && apic_on |=> clock_alarm_request_n_oe)
      else $error("alarm pin not driven with apic on");
   mouse_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R9
      mouse_reg && mouse_on && !port60_rd |=> mouse_reg)
      else $error("mouse latch dropped early");
   mouse_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R8
      clk_en && mouse_on && rise[IRQF_MOUSE_LINE] |=> mouse_reg)
      else $error("mouse edge not latched");
   mode_mask_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R1
      (mode_reg & ~IRQF_LEVEL_OK) == 16'h0000)
      else $error("fixed line made level sensitive");
   default_vec_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R3
      clk_en && ack_pulse && !ack_held |=> vec_reg == IRQF_DEFAULT_VEC)
      else $error("withdrawn request not answered with default vector");
   alarm_edge_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R4
      clk_en && alarm_fall && !ack_pulse |=> pend_reg[IRQF_RTC_LINE])
      else $error("alarm edge not latched");
   usb_pull_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R11
      clk_en && usb_irq |=> shared_pci_request_d_oe && !shared_pci_request_d_n)
      else $error("usb interrupt not driven on shared line");
   sync_path_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R14
      clk_en ##1 clk_en |-> sync_reg == $past(meta_reg))
      else $error("synchroniser stage skipped");
endmodule : irqf_front_end
`default_nettype wire

/* File: sim/irqf_dev_model.sv */
// board request sources that drive the front end pin bundle
`timescale 1ns/1ns
`default_nettype none
module irqf_dev_model
   import irqf_pkg::*;
(
   input wire logic aclk,
   input wire logic [15:0] hold_req,
   input wire logic hold_alarm,
   input wire logic [3:0] hold_shared,
   input wire logic read_strobe,
   output var irqf_pkg::irqf_pins_t pins
);
   // sources keep a request up until the bench withdraws it
   always_ff @(posedge aclk) begin
      pins.req <= hold_req;
      pins.clock_alarm_n <= ~hold_alarm;
      pins.shared_n <= ~hold_shared;
      pins.serial <= 1'b1;
      pins.iord_n <= ~read_strobe;
   end
endmodule : irqf_dev_model
`default_nettype wire

/* File: sim/irqf_front_end_tb_top.sv */
// self-checking bench of the interrupt request front end
`timescale 1ns/1ns
`default_nettype none
module interrupt_request_input_front_end_tb_top;
   import irqf_pkg::*;
   logic aclk, aresetn, usb_irq, system_control_interrupt, smbus_irq, rd_stb, hold_alarm;
   logic [3:0] io_addr_lo, hold_shared;
   logic [15:0] hold_req;
   irqf_pins_t pins;
   logic [31:0] awaddr, wdata, araddr, rdata, v;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp;
   logic pd_n, pd_oe, al_out, al_oe, apic_n, cpu_int, irq_out;
   int fail_count = 0;
   int checked = 0;
   logic [31:0] seed = 32'd53;
   int lines[10] = '{3, 4, 5, 6, 7, 9, 10, 11, 14, 15};
   int tgt[11] = '{3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15};
   int ln;
   irqf_dev_model u_model (.aclk(aclk), .hold_req(hold_req), .hold_alarm(hold_alarm),
      .hold_shared(hold_shared), .read_strobe(rd_stb), .pins(pins));
   irqf_front_end u_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .pins(pins),
      .usb_irq(usb_irq), .system_control_interrupt(system_control_interrupt),
      .smbus_irq(smbus_irq), .io_addr_lo(io_addr_lo),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .shared_pci_request_d_n(pd_n), .shared_pci_request_d_oe(pd_oe),
      .clock_alarm_request_n_out(al_out), .clock_alarm_request_n_oe(al_oe),
      .apic_routed_request_out_n(apic_n), .cpu_interrupt_out(cpu_int), .irq_out(irq_out));
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= {24'h0, a}; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, IRQF_RESP_OKAY});
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= {24'h0, a}; arvalid <= 1'b1; rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_rd
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [1:0] r;
      axi_rd(a, v, r);
      chk(v, exp);
   endtask : rd_chk
   task automatic reset_dut;
      aresetn <= 1'b0; hold_req <= 16'h0; hold_alarm <= 1'b0; hold_shared <= 4'h0;
      usb_irq <= 1'b0; system_control_interrupt <= 1'b0; rd_stb <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask : reset_dut
   // raise one source, optionally withdraw it, then acknowledge and read the vector
   task automatic ack_case(input int line, input bit keep);
      logic [1:0] r;
      reset_dut();
      if (line == 8) hold_alarm <= 1'b1;
      else hold_req[line] <= 1'b1;
      repeat (8) @(posedge aclk);
      if (!keep) begin
         hold_req <= 16'h0;
         hold_alarm <= 1'b0;
      end
      repeat (8) @(posedge aclk);
      axi_wr(IRQF_CTRL_OFF, 32'h90);
      axi_rd(IRQF_VEC_OFF, v, r);
   endtask : ack_case
   initial begin
      #200000;
      fail_count++;
      wrap_up();
   end
   initial begin
      logic [1:0] r;
      aresetn = 1'b0; hold_req = 16'h0; hold_alarm = 1'b0; hold_shared = 4'h0;
      usb_irq = 1'b0; system_control_interrupt = 1'b0; smbus_irq = 1'b0; rd_stb = 1'b0;
      io_addr_lo = 4'h0;
      awaddr = 32'h0; wdata = 32'h0; araddr = 32'h0;
      awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
      reset_dut();
      chk({31'h0, apic_n}, 32'h1);
      chk({31'h0, cpu_int}, 32'h0);
      rd_chk(IRQF_CTRL_OFF, IRQF_CTRL_RST);
      rd_chk(IRQF_MODE_OFF, {16'h0, IRQF_MODE_RST});
      rd_chk(IRQF_GPIO_OFF, 32'h3);
      axi_rd(8'h40, v, r);
      chk(v, 32'h0);
      chk({30'h0, r}, {30'h0, IRQF_RESP_SLVERR});
      axi_wr(IRQF_MODE_OFF, 32'hffff);
      rd_chk(IRQF_MODE_OFF, {16'h0, IRQF_LEVEL_OK});
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         ln = lines[seed % 10];
         reset_dut();
         axi_wr(IRQF_MASK_OFF, 32'h1);
         hold_req[ln] <= 1'b1;
         repeat (8) @(posedge aclk);
         chk({31'h0, cpu_int}, 32'h1);
         chk({31'h0, irq_out}, 32'h1);
         axi_wr(IRQF_CTRL_OFF, 32'h90);
         rd_chk(IRQF_VEC_OFF, ln);
         hold_req <= 16'h0;
         axi_wr(IRQF_STAT_OFF, 32'hf);
         repeat (2) @(posedge aclk);
         chk({31'h0, irq_out}, 32'h0);
         ack_case(ln, 1'b0);
         chk(v, {28'h0, IRQF_DEFAULT_VEC});
      end
      ack_case(8, 1'b1);
      chk(v, {28'h0, IRQF_RTC_LINE});
      ack_case(8, 1'b0);
      chk(v, {28'h0, IRQF_DEFAULT_VEC});
      reset_dut();
      axi_wr(IRQF_CTRL_OFF, 32'h12);
      hold_req[12] <= 1'b1;
      repeat (8) @(posedge aclk);
      hold_req[12] <= 1'b0;
      repeat (8) @(posedge aclk);
      axi_rd(IRQF_PEND_OFF, v, r);
      chk({31'h0, v[12]}, 32'h1);
      io_addr_lo <= IRQF_PORT60;
      rd_stb <= 1'b1;
      repeat (4) @(posedge aclk);
      rd_stb <= 1'b0;
      repeat (8) @(posedge aclk);
      axi_rd(IRQF_PEND_OFF, v, r);
      chk({31'h0, v[12]}, 32'h0);
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         ln = tgt[seed % 11];
         reset_dut();
         axi_wr(IRQF_ROUTE_OFF, ln);
         hold_shared[0] <= 1'b1;
         repeat (8) @(posedge aclk);
         axi_rd(IRQF_PEND_OFF, v, r);
         chk({31'h0, v[ln]}, 32'h1);
      end
      reset_dut();
      axi_wr(IRQF_MODE_OFF, 32'h20);
      hold_req[5] <= 1'b1;
      repeat (8) @(posedge aclk);
      axi_rd(IRQF_PEND_OFF, v, r);
      chk({31'h0, v[5]}, 32'h1);
      hold_req[5] <= 1'b0;
      repeat (8) @(posedge aclk);
      axi_rd(IRQF_PEND_OFF, v, r);
      chk({31'h0, v[5]}, 32'h0);
      reset_dut();
      axi_wr(IRQF_CTRL_OFF, 32'h01);
      system_control_interrupt <= 1'b1;
      usb_irq <= 1'b1;
      repeat (4) @(posedge aclk);
      chk({31'h0, apic_n}, 32'h0);
      chk({31'h0, al_oe}, 32'h1);
      chk({30'h0, pd_oe, pd_n}, 32'h2);
      wrap_up();
   end
endmodule : interrupt_request_input_front_end_tb_top
`default_nettype wire
